// File: verilog/fifo_port_pkg.sv
// Shared constants for the half-duplex FIFO port.
package fifo_port_pkg;
  localparam int DATA_W = 16;
  localparam int STAT_W = 2;
  localparam int ENTRY_W = 18;
  localparam int DEPTH = 64;
  localparam int BYTE_W = 8;
  localparam logic [1:0] MODE_FIFO_MASTER = 2'h0;
  localparam logic [1:0] MODE_FULL_MASTER = 2'h1;
  localparam logic [1:0] MODE_FULL_SLAVE = 2'h2;
  localparam logic DIR_OUT = 1'h1;
  localparam logic DIR_IN = 1'h0;
  typedef enum logic [2:0] {
    HS_IDLE,
    HS_REQ,
    HS_WAIT_ACK,
    HS_WAIT_REL,
    HS_DONE
  } hs_state_e;
endpackage

// File: verilog/word_buffer.sv
// Sixty-four entry synchronous word buffer with guarded push and pop.
`timescale 1ns/100ps
module word_buffer #(
  parameter int WIDTH = fifo_port_pkg::ENTRY_W,
  parameter int DEPTH = fifo_port_pkg::DEPTH
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic flush,
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  input wire logic pop,
  output logic [WIDTH-1:0] pop_data,
  output logic full,
  output logic empty,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic do_push;
  logic do_pop;

  assign full = (cnt_q == DEPTH[AW:0]);
  assign empty = (cnt_q == '0);
  assign level = cnt_q;
  assign pop_data = mem[rd_q];
  // Pushing into a full buffer or popping an empty one is dropped here as a last guard.
  assign do_push = push && !full;
  assign do_pop = pop && !empty;

  always_ff @(posedge ref_clk)
  begin
    if (do_push)
    begin
      mem[wr_q] <= push_data;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else if (flush)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (do_push)
      begin
        wr_q <= wr_q + 1'b1;
      end
      if (do_pop)
      begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
    end
  end
endmodule // word_buffer

// File: verilog/half_duplex_fifo_port.sv
// Half-duplex FIFO port: buffer plus frontplane handshake engine.
`timescale 1ns/100ps
// Notes on behaviour
// - Data moves one direction at a time.
// - Buffer holds 64 entries of 18 bits.
// - Three modes: FIFO master, full master, slave.
// - Moves words between connector and buffer.
// - Requests when data or space is available.
// - Passes levels without inversion correction.
// - Program one is high level on port.
// - Sample sixteen bits, or low eight bytewise.
// - Strobe starts each transfer.
// - Direction line high out, low in.
// - Host end low before last out, after last in.
module half_duplex_fifo_port #(
  parameter int DEPTH = fifo_port_pkg::DEPTH
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [1:0] hs_mode,
  input wire logic dir_out,
  input wire logic byte_mode,
  input wire logic flag_active_high,
  input wire logic dir_as_ctl,
  input wire logic ctl_level,
  input wire logic last_word,
  input wire logic host_valid,
  input wire logic [fifo_port_pkg::ENTRY_W-1:0] host_wdata,
  output logic host_ready,
  output logic host_rvalid,
  output logic [fifo_port_pkg::ENTRY_W-1:0] host_rdata,
  input wire logic host_rready,
  input wire logic [fifo_port_pkg::DATA_W-1:0] incoming_data_bus,
  input wire logic peripheral_ack_flag,
  output logic [fifo_port_pkg::DATA_W-1:0] outgoing_data_bus,
  output logic transfer_request_strobe,
  output logic transfer_direction_line,
  output logic host_last_word_line_n,
  output logic buf_full,
  output logic buf_empty
);
  fifo_port_pkg::hs_state_e state_q;
  logic dir_q;
  logic flag;
  logic push;
  logic pop;
  logic [fifo_port_pkg::ENTRY_W-1:0] push_data;
  logic [fifo_port_pkg::ENTRY_W-1:0] pop_data;
  logic can_move;
  logic is_slave;
  logic fe_push;
  logic fe_pop;
  logic [fifo_port_pkg::DATA_W-1:0] sample;
  logic [fifo_port_pkg::DATA_W-1:0] out_q;
  logic strobe_q;
  logic host_last_word_line_q;
  logic last_seen_q;
  logic dir_change;

  // Flag is low true unless software flips its sense.
  assign flag = flag_active_high ? peripheral_ack_flag : !peripheral_ack_flag;
  assign is_slave = (hs_mode == fifo_port_pkg::MODE_FULL_SLAVE);
  // Outgoing needs a word to send, incoming needs room to land one.
  assign can_move = dir_q ? !buf_empty : !buf_full;
  // Levels pass straight through; the host channel's inversion is left intact.
  assign sample = byte_mode ? {{(fifo_port_pkg::DATA_W-fifo_port_pkg::BYTE_W){1'b0}},
    incoming_data_bus[fifo_port_pkg::BYTE_W-1:0]} : incoming_data_bus;
  assign dir_change = (dir_out != dir_q);

  // Flushing waits for the engine to idle, so a word in flight is never lost.
  word_buffer #(
    .WIDTH(fifo_port_pkg::ENTRY_W),
    .DEPTH(DEPTH)
  ) u_buf (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .flush(dir_change && state_q == fifo_port_pkg::HS_IDLE),
    .push(push),
    .push_data(push_data),
    .pop(pop),
    .pop_data(pop_data),
    .full(buf_full),
    .empty(buf_empty),
    .level()
  );

  // Host side only reaches the buffer end that suits the current direction.
  assign host_ready = dir_q && !buf_full && !dir_change;
  assign host_rvalid = !dir_q && !buf_empty;
  assign host_rdata = pop_data;
  assign fe_push = !dir_q && (state_q == fifo_port_pkg::HS_WAIT_ACK) && flag && !buf_full;
  assign fe_pop = dir_q && (state_q == fifo_port_pkg::HS_WAIT_ACK) && flag && !buf_empty;
  assign push = dir_q ? (host_valid && host_ready) : fe_push;
  assign push_data = dir_q ? host_wdata : {last_word, 1'b0, sample};
  assign pop = dir_q ? fe_pop : (host_rvalid && host_rready);

  // Direction changes flush the buffer so stale words never cross over.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      dir_q <= fifo_port_pkg::DIR_IN;
    end
    else if (state_q == fifo_port_pkg::HS_IDLE)
    begin
      dir_q <= dir_out;
    end
  end

  // Handshake engine; in slave mode the peripheral flag opens each cycle.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= fifo_port_pkg::HS_IDLE;
    end
    else
    begin
      case (state_q)
        fifo_port_pkg::HS_IDLE:
        begin
          if (!dir_change && can_move && (!is_slave || flag))
          begin
            state_q <= fifo_port_pkg::HS_REQ;
          end
        end
        fifo_port_pkg::HS_REQ:
        begin
          state_q <= fifo_port_pkg::HS_WAIT_ACK;
        end
        fifo_port_pkg::HS_WAIT_ACK:
        begin
          if (flag)
          begin
            // FIFO mode pipelines: it does not wait for the flag to drop.
            state_q <= (hs_mode == fifo_port_pkg::MODE_FIFO_MASTER) ?
              fifo_port_pkg::HS_DONE : fifo_port_pkg::HS_WAIT_REL;
          end
        end
        fifo_port_pkg::HS_WAIT_REL:
        begin
          if (!flag)
          begin
            state_q <= fifo_port_pkg::HS_DONE;
          end
        end
        fifo_port_pkg::HS_DONE:
        begin
          state_q <= fifo_port_pkg::HS_IDLE;
        end
        default:
        begin
          state_q <= fifo_port_pkg::HS_IDLE;
        end
      endcase
    end
  end

  // Strobe rises with the request and drops once the flag answers.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      strobe_q <= 1'b0;
    end
    else if (state_q == fifo_port_pkg::HS_REQ)
    begin
      strobe_q <= 1'b1;
    end
    else if (state_q == fifo_port_pkg::HS_WAIT_ACK && flag)
    begin
      strobe_q <= 1'b0;
    end
  end
  assign transfer_request_strobe = strobe_q;

  // Outgoing word is held valid from the request through the acknowledge.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      out_q <= '0;
    end
    else if (dir_q && state_q == fifo_port_pkg::HS_IDLE && !buf_empty)
    begin
      out_q <= byte_mode ? {{(fifo_port_pkg::DATA_W-fifo_port_pkg::BYTE_W){1'b0}},
        pop_data[fifo_port_pkg::BYTE_W-1:0]} : pop_data[fifo_port_pkg::DATA_W-1:0];
    end
  end
  assign outgoing_data_bus = out_q;

  // Direction line may be handed to software as a plain control output.
  assign transfer_direction_line = dir_as_ctl ? ctl_level :
    (dir_q ? fifo_port_pkg::DIR_OUT : fifo_port_pkg::DIR_IN);

  // Host end: before the last outgoing word, after the last incoming one.
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      host_last_word_line_q <= 1'b0;
      last_seen_q <= 1'b0;
    end
    else
    begin
      last_seen_q <= fe_push && last_word;
      if (state_q == fifo_port_pkg::HS_DONE && !last_seen_q)
      begin
        host_last_word_line_q <= 1'b0;
      end
      // The head entry's top bit marks the host's final outgoing word.
      if (dir_q && !dir_change && state_q == fifo_port_pkg::HS_IDLE && !buf_empty &&
        pop_data[fifo_port_pkg::ENTRY_W-1])
      begin
        host_last_word_line_q <= 1'b1;
      end
      else if (last_seen_q)
      begin
        host_last_word_line_q <= 1'b1;
      end
    end
  end
  assign host_last_word_line_n = !host_last_word_line_q;
endmodule // half_duplex_fifo_port

// File: testbench/fifo_port_monitor.sv
// Pin-level checks for the half-duplex FIFO port.
`timescale 1ns/100ps
module fifo_port_monitor (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic dir_out,
  input wire logic byte_mode,
  input wire logic flag_active_high,
  input wire logic dir_as_ctl,
  input wire logic ctl_level,
  input wire logic host_ready,
  input wire logic host_rvalid,
  input wire logic [17:0] host_rdata,
  input wire logic peripheral_ack_flag,
  input wire logic [15:0] outgoing_data_bus,
  input wire logic transfer_request_strobe,
  input wire logic transfer_direction_line,
  input wire logic buf_full,
  input wire logic buf_empty
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  AST_DIR: assert property (
    (!dir_as_ctl && $stable(dir_out))[*3] ##0 $rose(transfer_request_strobe)
    |-> transfer_direction_line == dir_out)
    else $error("direction line off");
  AST_CTL: assert property (
    (dir_as_ctl && $stable(ctl_level))[*3] |-> transfer_direction_line == ctl_level)
    else $error("control level off");
  AST_NO_PUSH_FULL: assert property (buf_full |-> !host_ready)
    else $error("push offered while full");
  AST_NO_POP_EMPTY: assert property (buf_empty |-> !host_rvalid)
    else $error("pop offered while empty");
  AST_STROBE_HOLD: assert property (
    transfer_request_strobe && peripheral_ack_flag != flag_active_high ##1 $stable(dir_out)
    |-> transfer_request_strobe)
    else $error("strobe dropped early");
  AST_OUT_NEEDS_DATA: assert property (
    $rose(transfer_request_strobe) && !dir_as_ctl && transfer_direction_line |-> !buf_empty)
    else $error("outgoing request with no data");
  AST_IN_NEEDS_SPACE: assert property (
    $rose(transfer_request_strobe) && !dir_as_ctl && !transfer_direction_line |-> !buf_full)
    else $error("incoming request with no space");
  AST_DATA_HELD: assert property (
    transfer_request_strobe && $past(transfer_request_strobe) |-> $stable(outgoing_data_bus))
    else $error("outgoing data moved");
  AST_BYTE_UPPER: assert property (
    host_rvalid && byte_mode |-> host_rdata[15:8] == 8'h00)
    else $error("byte entry upper bits set");
endmodule // fifo_port_monitor
bind half_duplex_fifo_port fifo_port_monitor mon (.*);

// File: testbench/periph_model.sv
// Behavioural peripheral on the frontplane handshake.
`timescale 1ns/100ps
module periph_model (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic transfer_request_strobe,
  input wire logic go,
  input wire logic [3:0] delay,
  input wire logic [15:0] in_word,
  input wire logic [15:0] outgoing_data_bus,
  output logic peripheral_ack_flag,
  output logic [15:0] incoming_data_bus,
  output logic took,
  output logic [15:0] got
);
  logic [3:0] cnt_q;
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      peripheral_ack_flag <= 1'b1;
      incoming_data_bus <= 16'h0000;
      cnt_q <= 4'h0;
      took <= 1'b0;
      got <= 16'h0000;
    end
    else
    begin
      took <= 1'b0;
      if (peripheral_ack_flag && (transfer_request_strobe || go))
      begin
        cnt_q <= cnt_q + 4'h1;
        if (cnt_q >= delay)
        begin
          // Flag and word land together so the port samples a settled word.
          peripheral_ack_flag <= 1'b0;
          incoming_data_bus <= in_word;
          got <= outgoing_data_bus;
          took <= 1'b1;
          cnt_q <= 4'h0;
        end
      end
      else if (!peripheral_ack_flag && !transfer_request_strobe && !go)
      begin
        // A released bus must not keep showing the old word.
        peripheral_ack_flag <= 1'b1;
        incoming_data_bus <= ~incoming_data_bus;
      end
    end
  end
endmodule // periph_model

// File: testbench/test_half_duplex_fifo_port.sv
// Self-checking bench for the half-duplex FIFO port.
`timescale 1ns/100ps
module test_half_duplex_fifo_port;
  logic ref_clk = 1'b0;
  logic rstn;
  logic [1:0] hs_mode = 2'h0;
  logic dir_out = 1'b1;
  logic byte_mode = 1'b0;
  logic flag_active_high = 1'b0;
  logic dir_as_ctl = 1'b0;
  logic ctl_level = 1'b0;
  logic last_word = 1'b0;
  logic host_valid = 1'b0;
  logic host_rready = 1'b0;
  logic go = 1'b0;
  logic [3:0] delay = 4'h0;
  logic [15:0] in_word = 16'h0000;
  logic [17:0] host_wdata = 18'h00000;
  logic host_ready, host_rvalid, peripheral_ack_flag, took, buf_full, buf_empty;
  logic transfer_request_strobe, transfer_direction_line, host_last_word_line_n;
  logic [17:0] host_rdata;
  logic [15:0] incoming_data_bus, outgoing_data_bus, got;
  logic [15:0] exp_q[$];
  logic saw_host_last_word_line = 1'b0;
  int bad_count = 0;
  int total_checks = 0;
  int cyc = 0;
  half_duplex_fifo_port dut (.*);
  periph_model far_end (.*);
  always #5 ref_clk = ~ref_clk;
  task automatic chk(input logic ok);
    total_checks++;
    if (ok !== 1'b1)
    begin
      bad_count++;
      $display("unexpected at %0t: pin value differs", $time);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge ref_clk)
  begin
    cyc++;
    if (!host_last_word_line_n)
      saw_host_last_word_line = 1'b1;
    if (took && dir_out && exp_q.size() > 0)
    begin
      chk(host_last_word_line_n === (exp_q.size() != 1));
      chk(got === exp_q.pop_front());
    end
    if (cyc == 20000)
    begin
      bad_count++;
      summarize();
    end
  end
  task automatic push(input logic [17:0] w);
    @(posedge ref_clk);
    host_wdata <= w;
    last_word <= w[17];
    host_valid <= 1'b1;
    do @(negedge ref_clk); while (host_ready !== 1'b1);
    @(posedge ref_clk);
    host_valid <= 1'b0;
  endtask
  task automatic t_out(input logic [1:0] m, input logic [3:0] d);
    @(posedge ref_clk);
    hs_mode <= m;
    delay <= d;
    saw_host_last_word_line = 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      exp_q.push_back(16'hA5C0 + 16'(i));
      push({i == 2, 1'b0, 16'hA5C0 + 16'(i)});
    end
    for (int n = 0; n < 300 && exp_q.size() > 0; n++)
      @(posedge ref_clk);
    // The last pop lands on the same edge, so look once it has settled.
    @(negedge ref_clk);
    chk(exp_q.size() == 0 && saw_host_last_word_line && buf_empty);
  endtask
  task automatic t_in(input logic b, input logic [1:0] m, input logic g);
    @(posedge ref_clk);
    dir_out <= 1'b0;
    byte_mode <= b;
    hs_mode <= m;
    go <= g;
    in_word <= 16'h5AC3;
    for (int n = 0; n < 300 && host_rvalid !== 1'b1; n++)
      @(negedge ref_clk);
    chk(host_rdata[15:0] === (b ? 16'h00C3 : 16'h5AC3));
    chk(transfer_direction_line === fifo_port_pkg::DIR_IN);
    @(posedge ref_clk);
    go <= 1'b0;
    dir_out <= 1'b1;
    // The switch waits for the engine to idle; the next scenario must not start earlier.
    for (int n = 0; n < 300 && transfer_direction_line !== fifo_port_pkg::DIR_OUT; n++)
      @(negedge ref_clk);
    chk(transfer_direction_line === fifo_port_pkg::DIR_OUT);
  endtask
  task automatic t_fill();
    int k;
    k = 0;
    @(posedge ref_clk);
    dir_out <= 1'b0;
    hs_mode <= fifo_port_pkg::MODE_FULL_MASTER;
    for (int n = 0; n < 1500 && buf_full !== 1'b1; n++)
      @(negedge ref_clk);
    repeat (8) @(negedge ref_clk);
    chk(buf_full === 1'b1 && transfer_request_strobe === 1'b0);
    @(posedge ref_clk);
    // Slave mode with no peripheral flag stalls refills while draining.
    hs_mode <= fifo_port_pkg::MODE_FULL_SLAVE;
    host_rready <= 1'b1;
    for (int n = 0; n < 300 && buf_empty !== 1'b1; n++)
    begin
      @(posedge ref_clk);
      k += int'(host_rvalid === 1'b1);
    end
    chk(k == fifo_port_pkg::DEPTH);
    host_rready <= 1'b0;
  endtask
  initial
  begin
    rstn = 1'b0;
    @(negedge ref_clk);
    chk(!transfer_request_strobe && host_last_word_line_n && buf_empty);
    chk(transfer_direction_line === fifo_port_pkg::DIR_IN);
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    t_out(fifo_port_pkg::MODE_FIFO_MASTER, 4'h0);
    t_out(fifo_port_pkg::MODE_FULL_MASTER, 4'h5);
    t_in(1'b0, fifo_port_pkg::MODE_FULL_MASTER, 1'b0);
    t_in(1'b1, fifo_port_pkg::MODE_FIFO_MASTER, 1'b0);
    t_in(1'b0, fifo_port_pkg::MODE_FULL_SLAVE, 1'b1);
    t_fill();
    @(posedge ref_clk);
    dir_as_ctl <= 1'b1;
    ctl_level <= 1'b1;
    repeat (5) @(negedge ref_clk);
    chk(transfer_direction_line === 1'b1);
    summarize();
  end
endmodule // test_half_duplex_fifo_port
